// File: core/bsc_ctrl.sv
/*
  Top of the sensorless motor control: duty source select, 20 kHz PWM, commutation
  sequencer with forced start, back-EMF lock, lead angle, fault stop and gate drive.
  Assumes all inputs synchronous to ref_clk; ADC codes arrive already converted.
*/
module bsc_ctrl #(
  parameter int PWM_PERIOD_CYC = bsc_pkg::PWM_PERIOD_CYC,
  parameter int PWM_COMMAND_INPUT_TIMEOUT_CYC = bsc_pkg::PWM_COMMAND_INPUT_TIMEOUT_CYC,
  parameter longint FC_STEP_NUM = bsc_pkg::FC_STEP_NUM
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic regulated_logic_supply_uv,
  input wire logic pwm_command_input,
  input wire logic [7:0] analog_command_input,
  input wire logic output_disable,
  input wire logic [7:0] forced_commutation_select,
  input wire logic forced_commutation_open,
  input wire bsc_pkg::bsc_lvl_t lead_angle_select,
  input wire logic direction_select,
  input wire logic overvoltage_flag,
  input wire logic current_limit_flag,
  input wire logic overcurrent_flag,
  input wire logic [2:0] bemf_compare,
  output logic high_side_gate_u,
  output logic high_side_gate_v,
  output logic high_side_gate_w,
  output logic low_side_gate_u,
  output logic low_side_gate_v,
  output logic low_side_gate_w,
  output logic high_side_gate_u_oe,
  output logic high_side_gate_v_oe,
  output logic high_side_gate_w_oe,
  output logic low_side_gate_u_oe,
  output logic low_side_gate_v_oe,
  output logic low_side_gate_w_oe,
  output logic rotation_pulse_out,
  output logic source_is_pwm
);
  import bsc_pkg::*;

  typedef struct packed {
    bsc_state_t st;
    logic [2:0] step;
    logic [15:0] pwm_cnt;
    logic [15:0] thr;
    logic chop;
    logic src_pwm;
    logic [7:0] meas;
    logic [7:0] duty;
    logic [25:0] tmr;
    logic [25:0] dly;
    logic armed;
    logic [2:0] zc_cnt;
    logic bemf_prev;
    logic [5:0] gate;
    logic oe;
    logic fg;
  } bsc_ctrl_t;

  bsc_ctrl_t r_reg;
  bsc_ctrl_t r_next;
  logic irst;
  logic pwm_on;
  logic [2:0] fc_code;
  logic [25:0] fc_cyc;
  logic bemf_now;
  logic zc;
  logic [2:0] step_adv;
  logic stop;

  bsc_meas_if u_if();

  assign irst = !rstn || regulated_logic_supply_uv;
  assign u_if.clk = ref_clk;
  assign u_if.rst = irst;
  assign u_if.cmd_in = pwm_command_input;

  bsc_meas #(
    .PWM_COMMAND_INPUT_TIMEOUT_CYC(PWM_COMMAND_INPUT_TIMEOUT_CYC)
  ) u_meas (
    .m(u_if.meas)
  );

  assign pwm_on = r_reg.pwm_cnt < r_reg.thr;
  assign fc_code = forced_commutation_open ? FC_OPEN_CODE : forced_commutation_select[7:5];
  assign fc_cyc = fc_step(fc_code, FC_STEP_NUM);
  assign bemf_now = bemf_compare[fl_of(r_reg.step)];
  assign zc = (bemf_now != r_reg.bemf_prev) && (r_reg.tmr > 26'(BLANK_CYC)) && !r_reg.armed;
  always_comb begin
    if (direction_select) begin
      step_adv = (r_reg.step == 3'h0) ? 3'h5 : r_reg.step - 3'h1;
    end else begin
      step_adv = (r_reg.step == 3'h5) ? 3'h0 : r_reg.step + 3'h1;
    end
  end
  assign stop = overvoltage_flag || overcurrent_flag;

  always_comb begin
    r_next = r_reg;
    r_next.bemf_prev = bemf_now;
    if (r_reg.pwm_cnt == 16'(PWM_PERIOD_CYC - 1)) begin
      r_next.pwm_cnt = '0;
      r_next.thr = pwm_thr(r_reg.duty, PWM_PERIOD_CYC);
      r_next.chop = 1'b0;
    end else begin
      r_next.pwm_cnt = r_reg.pwm_cnt + 16'h1;
    end
    if (current_limit_flag && pwm_on) begin
      r_next.chop = 1'b1;
    end
    if (u_if.duty_vld) begin
      r_next.meas = u_if.duty;
      if (u_if.duty >= pct(6) && u_if.duty <= pct(94)) begin
        r_next.src_pwm = 1'b1;
      end else if (u_if.duty <= pct(4) || u_if.duty >= pct(96)) begin
        r_next.src_pwm = 1'b0;
      end
    end
    r_next.duty = r_next.src_pwm ? r_next.meas : analog_command_input;
    unique case (r_reg.st)
      ST_IDLE: begin
        r_next.tmr = '0;
        r_next.zc_cnt = '0;
        r_next.armed = 1'b0;
        if (r_reg.duty != 8'h00) begin
          r_next.st = ST_FORCED;
        end
      end
      ST_FORCED: begin
        r_next.tmr = r_reg.tmr + 26'h1;
        if (zc) begin
          r_next.armed = 1'b1;
          r_next.zc_cnt = r_reg.zc_cnt + 3'h1;
        end
        if (r_reg.tmr >= fc_cyc - 26'h1) begin
          r_next.step = step_adv;
          r_next.tmr = '0;
          r_next.armed = 1'b0;
          if (!r_reg.armed && !zc) begin
            r_next.zc_cnt = '0;
          end
        end
        if (r_reg.zc_cnt == ZC_LOCK - 3'h1 && zc) begin
          r_next.st = ST_RUN;
          r_next.dly = lead_dly(r_reg.tmr, lead_angle_select);
        end
      end
      ST_RUN: begin
        r_next.tmr = r_reg.tmr + 26'h1;
        if (zc) begin
          r_next.armed = 1'b1;
          r_next.dly = lead_dly(r_reg.tmr, lead_angle_select);
        end else if (r_reg.armed) begin
          if (r_reg.dly == '0) begin
            r_next.step = step_adv;
            r_next.tmr = '0;
            r_next.armed = 1'b0;
          end else begin
            r_next.dly = r_reg.dly - 26'h1;
          end
        end
        if (r_reg.tmr >= {fc_cyc[24:0], 1'b0}) begin
          r_next.st = ST_IDLE;
        end
      end
      ST_FAULT: begin
        r_next.armed = 1'b0;
        if (!stop) begin
          r_next.st = ST_IDLE;
        end
      end
    endcase
    if (r_reg.duty == 8'h00 && r_reg.st != ST_FAULT) begin
      r_next.st = ST_IDLE;
    end
    if (stop) begin
      r_next.st = ST_FAULT;
    end
    r_next.gate = '0;
    if (r_reg.st == ST_FORCED || r_reg.st == ST_RUN) begin
      r_next.gate[3 + hs_of(r_reg.step)] = 1'b1;
      r_next.gate[ls_of(r_reg.step)] = pwm_on && !r_next.chop;
    end
    if (r_next.st == ST_FAULT || r_next.st == ST_IDLE) begin
      r_next.gate = '0;
    end
    r_next.oe = !output_disable;
    r_next.fg = r_reg.step < 3'h3;
  end

  always_ff @(posedge ref_clk) begin
    if (irst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign high_side_gate_u = r_reg.gate[3];
  assign high_side_gate_v = r_reg.gate[4];
  assign high_side_gate_w = r_reg.gate[5];
  assign low_side_gate_u = r_reg.gate[0];
  assign low_side_gate_v = r_reg.gate[1];
  assign low_side_gate_w = r_reg.gate[2];
  assign high_side_gate_u_oe = r_reg.oe;
  assign high_side_gate_v_oe = r_reg.oe;
  assign high_side_gate_w_oe = r_reg.oe;
  assign low_side_gate_u_oe = r_reg.oe;
  assign low_side_gate_v_oe = r_reg.oe;
  assign low_side_gate_w_oe = r_reg.oe;
  assign rotation_pulse_out = r_reg.fg;
  assign source_is_pwm = r_reg.src_pwm;
endmodule

// File: core/bsc_meas.sv
/*
  Command PWM duty meter: glitch filter, period and high-time counters, serial divider.
  Assumes a synchronous active-high reset carried in the interface.
*/
module bsc_meas #(
  parameter int PWM_COMMAND_INPUT_TIMEOUT_CYC = bsc_pkg::PWM_COMMAND_INPUT_TIMEOUT_CYC
) (
  bsc_meas_if.meas m
);
  import bsc_pkg::*;

  typedef struct packed {
    logic lvl;
    logic [11:0] stab;
    logic [24:0] per;
    logic [24:0] hi;
    logic busy;
    logic [25:0] rem;
    logic [24:0] dper;
    logic [7:0] q;
    logic [2:0] bits;
    logic [7:0] duty;
    logic vld;
  } bsc_meas_t;

  bsc_meas_t r_reg;
  bsc_meas_t r_next;

  always_comb begin
    logic [25:0] r2;
    r2 = {r_reg.rem[24:0], 1'b0};
    r_next = r_reg;
    r_next.vld = 1'b0;
    r_next.per = r_reg.per + 25'h1;
    if (r_reg.lvl) begin
      r_next.hi = r_reg.hi + 25'h1;
    end
    if (r_reg.per == 25'(PWM_COMMAND_INPUT_TIMEOUT_CYC - 1)) begin
      r_next.duty = r_reg.lvl ? DUTY_FULL : 8'h00;
      r_next.vld = 1'b1;
      r_next.per = '0;
      r_next.hi = '0;
    end
    if (m.cmd_in != r_reg.lvl) begin
      if (r_reg.stab == 12'(GLITCH_CYC)) begin
        r_next.lvl = m.cmd_in;
        r_next.stab = '0;
        if (m.cmd_in && !r_reg.busy) begin
          r_next.busy = 1'b1;
          r_next.rem = {1'b0, r_reg.hi};
          r_next.dper = r_reg.per;
          r_next.bits = '0;
          r_next.q = '0;
          r_next.per = '0;
          r_next.hi = '0;
        end
      end else begin
        r_next.stab = r_reg.stab + 12'h1;
      end
    end else begin
      r_next.stab = '0;
    end
    if (r_reg.busy) begin
      if (r2 >= {1'b0, r_reg.dper}) begin
        r_next.rem = r2 - {1'b0, r_reg.dper};
        r_next.q = {r_reg.q[6:0], 1'b1};
      end else begin
        r_next.rem = r2;
        r_next.q = {r_reg.q[6:0], 1'b0};
      end
      r_next.bits = r_reg.bits + 3'h1;
      if (r_reg.bits == 3'h7) begin
        r_next.busy = 1'b0;
        r_next.duty = r_next.q;
        r_next.vld = 1'b1;
      end
    end
  end

  always_ff @(posedge m.clk) begin
    if (m.rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign m.duty = r_reg.duty;
  assign m.duty_vld = r_reg.vld;
endmodule

// File: core/bsc_meas_if.sv
/*
  Carrier between the control core and the command duty meter.
  Assumes the control core drives clock, reset and the raw command level.
*/
interface bsc_meas_if;
  logic clk;
  logic rst;
  logic cmd_in;
  logic [7:0] duty;
  logic duty_vld;
  modport meas(input clk, input rst, input cmd_in, output duty, output duty_vld);
  modport ctrl(output clk, output rst, output cmd_in, input duty, input duty_vld);
endinterface

// File: core/bsc_pkg.sv
/*
  Shared constants, types and helper functions of the sensorless motor control block.
  Assumes one 200 MHz clock; all inputs are already synchronous to it.
*/
// What this block does
// - time the PWM command's period and high time, turn duty into gate PWM
// - analog command code becomes duty; open input (pulled up) gives 100%
// - output disable high puts all six gate outputs in high impedance
// - select voltage decodes to eight forced-commutation speeds, 391 to 25000 rpm
// - open forced-commutation select gives the 1563 rpm setting
// - lead angle select: low 7.5, high 15, middle or open 30 degrees
// - direction select low runs clockwise, high counterclockwise
// - overvoltage flag stops rotation by ending commutation drive
// - 100 mV flag limits current, 200 mV flag is overcurrent
// - logic supply undervoltage resets all internal logic
// - loss of rotor sync is detected and the motor restarts
// - only low-side gates are chopped; high side follows the pattern
// - all timing derives from the reference clock
// - internal PWM runs at 20 kHz with the selected duty
// - measured duty used between 6% and 94%, analog at or beyond 4%/96%
// - source switching has 2% hysteresis
// - command pulses of 10 us or less are rejected; PWM is active high
package bsc_pkg;
  localparam longint CLK_HZ = 200_000_000;
  localparam int PWM_HZ = 20_000;
  localparam int PWM_PERIOD_CYC = int'(CLK_HZ / PWM_HZ);
  localparam int GLITCH_NS = 10_000;
  localparam int GLITCH_CYC = int'((longint'(GLITCH_NS) * CLK_HZ) / 1_000_000_000);
  localparam int PWM_COMMAND_INPUT_MIN_HZ = 10;
  localparam int PWM_COMMAND_INPUT_TIMEOUT_CYC = int'(CLK_HZ / PWM_COMMAND_INPUT_MIN_HZ);
  localparam longint FC_STEP_NUM = CLK_HZ * 10;
  localparam logic [2:0] FC_OPEN_CODE = 3'h3;
  localparam logic [15:0] BLANK_CYC = 16'h0040;
  localparam logic [2:0] ZC_LOCK = 3'h6;
  localparam logic [7:0] DUTY_FULL = 8'hFF;

  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_MID = 2'h2
  } bsc_lvl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FORCED = 2'h1,
    ST_RUN = 2'h3,
    ST_FAULT = 2'h2
  } bsc_state_t;

  function automatic logic [7:0] pct(input int p);
    return 8'((p * 255) / 100);
  endfunction

  function automatic logic [25:0] fc_step(input logic [2:0] code, input longint num);
    int rpm;
    unique case (code)
      3'h7: rpm = 25000;
      3'h6: rpm = 12500;
      3'h5: rpm = 6250;
      3'h4: rpm = 3125;
      3'h3: rpm = 1563;
      3'h2: rpm = 781;
      3'h1: rpm = 391;
      3'h0: rpm = 9375;
    endcase
    return 26'(num / rpm);
  endfunction

  function automatic logic [15:0] pwm_thr(input logic [7:0] d, input int period);
    if (d == DUTY_FULL) begin
      return 16'(period);
    end
    return 16'((int'(d) * period) >> 8);
  endfunction

  function automatic logic [25:0] lead_dly(input logic [25:0] h, input bsc_lvl_t la);
    unique case (la)
      LVL_LOW: lead_dly = (h >> 1) + (h >> 2);
      LVL_HIGH: lead_dly = h >> 1;
      default: lead_dly = '0;
    endcase
  endfunction

  function automatic logic [1:0] hs_of(input logic [2:0] s);
    return 2'(s >> 1);
  endfunction

  function automatic logic [1:0] ls_of(input logic [2:0] s);
    unique case (s)
      3'h0, 3'h5: ls_of = 2'h1;
      3'h1, 3'h2: ls_of = 2'h2;
      default: ls_of = 2'h0;
    endcase
  endfunction

  function automatic logic [1:0] fl_of(input logic [2:0] s);
    unique case (s)
      3'h0, 3'h3: fl_of = 2'h2;
      3'h1, 3'h4: fl_of = 2'h1;
      default: fl_of = 2'h0;
    endcase
  endfunction
endpackage

// File: verification/bsc_ctrl_assertions.sv
/*
  Port checker for bsc_ctrl, bound to every instance.
  Assumes one clock and a synchronous reset.
*/
module bsc_ctrl_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic regulated_logic_supply_uv,
  input wire logic output_disable,
  input wire logic overvoltage_flag,
  input wire logic overcurrent_flag,
  input wire logic high_side_gate_u,
  input wire logic high_side_gate_v,
  input wire logic high_side_gate_w,
  input wire logic low_side_gate_u,
  input wire logic low_side_gate_v,
  input wire logic low_side_gate_w,
  input wire logic high_side_gate_u_oe,
  input wire logic high_side_gate_v_oe,
  input wire logic high_side_gate_w_oe,
  input wire logic low_side_gate_u_oe,
  input wire logic low_side_gate_v_oe,
  input wire logic low_side_gate_w_oe,
  input wire logic source_is_pwm
);
  wire logic [2:0] hs = {high_side_gate_w, high_side_gate_v, high_side_gate_u};
  wire logic [2:0] ls = {low_side_gate_w, low_side_gate_v, low_side_gate_u};
  wire logic [5:0] oe = {high_side_gate_w_oe, high_side_gate_v_oe, high_side_gate_u_oe,
    low_side_gate_w_oe, low_side_gate_v_oe, low_side_gate_u_oe};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn || regulated_logic_supply_uv);
  a_dis_float: assert property (output_disable |=> oe == 6'h00)
    else $error("outputs driven while disabled");
  a_en_drive: assert property (!output_disable |=> oe == 6'h3F)
    else $error("outputs floating while enabled");
  a_rst_off: assert property (disable iff (1'b0) !rstn |=> {hs, ls, oe} == 12'h000)
    else $error("gates active in reset");
  a_uv_clear: assert property (disable iff (1'b0)
    regulated_logic_supply_uv |=> !source_is_pwm && {hs, ls} == 6'h00)
    else $error("logic not cleared on undervoltage");
  a_ov_stop: assert property (overvoltage_flag [*2] |=> {hs, ls} == 6'h00)
    else $error("drive on during overvoltage");
  a_oc_stop: assert property (overcurrent_flag [*2] |=> {hs, ls} == 6'h00)
    else $error("drive on during overcurrent");
  a_hs_single: assert property ($onehot0(hs))
    else $error("two high side gates on");
  a_ls_single: assert property ($onehot0(ls))
    else $error("two low side gates on");
  a_no_shoot: assert property ((hs & ls) == 3'h0)
    else $error("both gates of a phase on");
endmodule

bind bsc_ctrl bsc_ctrl_chk i_bsc_ctrl_chk (.ref_clk(ref_clk), .rstn(rstn),
  .regulated_logic_supply_uv(regulated_logic_supply_uv), .output_disable(output_disable),
  .overvoltage_flag(overvoltage_flag), .overcurrent_flag(overcurrent_flag),
  .high_side_gate_u(high_side_gate_u), .high_side_gate_v(high_side_gate_v),
  .high_side_gate_w(high_side_gate_w), .low_side_gate_u(low_side_gate_u),
  .low_side_gate_v(low_side_gate_v), .low_side_gate_w(low_side_gate_w),
  .high_side_gate_u_oe(high_side_gate_u_oe), .high_side_gate_v_oe(high_side_gate_v_oe),
  .high_side_gate_w_oe(high_side_gate_w_oe), .low_side_gate_u_oe(low_side_gate_u_oe),
  .low_side_gate_v_oe(low_side_gate_v_oe), .low_side_gate_w_oe(low_side_gate_w_oe),
  .source_is_pwm(source_is_pwm));

// File: verification/bsc_motor_model.sv
/*
  Behavioural motor and bridge: flips the comparators a delay after each commutation.
  Assumes gate levels settled just after the clock edge.
*/
module bsc_motor_model #(
  parameter int DLY = 300
) (
  input wire logic ref_clk,
  input wire logic [2:0] hs,
  input wire logic [2:0] ls,
  input wire logic stall,
  output logic [2:0] bemf_compare
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hs_reg = 3'h0;
  logic [2:0] lp_reg = 3'h0;
  int cnt = 0;
  logic [2:0] bemf_reg = 3'h0;
  assign bemf_compare = bemf_reg;
  // crossing after each step, none when stalled
  always @(posedge ref_clk) begin
    if (hs != hs_reg || (ls != 3'h0 && ls != lp_reg)) begin
      cnt <= DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    if (cnt == 1 && !stall) begin
      bemf_reg <= #1 ~bemf_reg;
    end
    hs_reg <= hs;
    if (ls != 3'h0) begin
      lp_reg <= ls;
    end
  end
endmodule

// File: verification/test_bsc_ctrl.sv
/*
  Self-checking bench for bsc_ctrl with the motor model.
  Assumes the bound port checker.
*/
module test_bsc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rstn = 0, uv = 0, cmd = 0, dis = 0, fco = 0, dir = 0;
  logic ov = 0, oc = 0, cl = 0, stall = 0;
  logic [7:0] ana = 8'h80, fcs = 8'hE0;
  logic [2:0] a;
  bsc_pkg::bsc_lvl_t la = bsc_pkg::LVL_MID;
  int tl [3];
  wire logic [2:0] hs, ls, bemf;
  wire logic [5:0] oe;
  wire logic src, fg;
  int fails = 0, tests_run = 0, t;
  int rpm_tab [9] = '{9375, 391, 781, 1563, 3125, 6250, 12500, 25000, 1563};
  always #2.5 ref_clk = ~ref_clk;
  bsc_ctrl #(.PWM_PERIOD_CYC(100), .PWM_COMMAND_INPUT_TIMEOUT_CYC(10000), .FC_STEP_NUM(2_000_000))
    i_bsc_ctrl (.ref_clk(ref_clk), .rstn(rstn), .regulated_logic_supply_uv(uv),
    .pwm_command_input(cmd), .analog_command_input(ana), .output_disable(dis),
    .forced_commutation_select(fcs), .forced_commutation_open(fco),
    .lead_angle_select(la), .direction_select(dir), .overvoltage_flag(ov),
    .current_limit_flag(cl), .overcurrent_flag(oc), .bemf_compare(bemf),
    .high_side_gate_u(hs[0]), .high_side_gate_v(hs[1]), .high_side_gate_w(hs[2]),
    .low_side_gate_u(ls[0]), .low_side_gate_v(ls[1]), .low_side_gate_w(ls[2]),
    .high_side_gate_u_oe(oe[5]), .high_side_gate_v_oe(oe[4]), .high_side_gate_w_oe(oe[3]),
    .low_side_gate_u_oe(oe[2]), .low_side_gate_v_oe(oe[1]), .low_side_gate_w_oe(oe[0]),
    .rotation_pulse_out(fg), .source_is_pwm(src));
  bsc_motor_model i_bsc_motor_model (.ref_clk(ref_clk), .hs(hs), .ls(ls), .stall(stall),
    .bemf_compare(bemf));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
      fails++;
    end
  endtask
  task automatic rst();
    rstn = 0;
    cyc(4);
    rstn = 1;
  endtask
  task automatic duty(input int e);
    int c, h;
    for (int k = 0; k < 3; k++) begin
      c = 0;
      h = 0;
      repeat (100) begin
        cyc(1);
        c += int'(|ls);
        h += int'(|hs);
      end
      if (c == e) break;
    end
    chk("low side on cycles", 16'(e), 16'(c));
    chk("high side on cycles", 16'h0064, 16'(h));
  endtask
  task automatic hs_wait();
    logic [2:0] h;
    h = hs;
    t = 0;
    while (hs === h && t < 30000) begin
      cyc(1);
      t++;
    end
    if (t >= 30000) fails++;
  endtask
  task automatic pulse(input int h, input int l);
    cmd = 1;
    cyc(h);
    cmd = 0;
    cyc(l);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #500_000;
    fails++;
    close_out();
  end
  initial begin
    rst();
    cyc(2);
    chk("oe after reset", 16'h003F, 16'(oe));
    cyc(300);
    duty(50);
    ana = 8'hFF;
    cyc(200);
    duty(100);
    cl = 1;
    cyc(5);
    duty(0);
    cl = 0;
    dis = 1;
    cyc(2);
    chk("oe disabled", 16'h0000, 16'(oe));
    dis = 0;
    cyc(2);
    chk("oe enabled", 16'h003F, 16'(oe));
    $display("test drive done");
    ov = 1;
    cyc(3);
    chk("gates overvoltage", 16'h0000, 16'({hs, ls}));
    ov = 0;
    oc = 1;
    cyc(3);
    chk("gates overcurrent", 16'h0000, 16'({hs, ls}));
    oc = 0;
    uv = 1;
    cyc(2);
    chk("source undervoltage", 16'h0000, 16'(src));
    chk("gates undervoltage", 16'h0000, 16'({hs, ls}));
    uv = 0;
    $display("test faults done");
    repeat (3) pulse(1500, 2500);
    chk("source short pulses", 16'h0000, 16'(src));
    repeat (2) pulse(4000, 4000);
    chk("source pwm", 16'h0001, 16'(src));
    duty(50);
    cmd = 1;
    cyc(12100);
    chk("source timeout", 16'h0000, 16'(src));
    ana = 8'h40;
    cyc(200);
    duty(25);
    $display("test command done");
    stall = 1;
    for (int i = 0; i < 9; i++) begin
      fcs = {3'(i), 5'h00};
      fco = (i == 8);
      rst();
      repeat (2) hs_wait();
      chk("forced interval", 16'(2 * (2_000_000 / rpm_tab[i])), 16'(t));
    end
    fcs = 8'hE0;
    fco = 0;
    for (int d = 0; d < 2; d++) begin
      dir = d[0];
      rst();
      repeat (2) hs_wait();
      a = hs;
      chk("rotation pulse", 16'(!dir), 16'(fg));
      hs_wait();
      chk("direction", 16'(dir ? {a[0], a[2:1]} : {a[1:0], a[2]}), 16'(hs));
    end
    $display("test speed done");
    stall = 0;
    ana = 8'hFF;
    fcs = 8'hA0;
    for (int j = 0; j < 3; j++) begin
      la = bsc_pkg::bsc_lvl_t'(j);
      rst();
      repeat (7) hs_wait();
      tl[j] = t;
    end
    chk("lead order", 16'h0001, 16'(tl[0] > tl[1] && tl[1] > tl[2]));
    chk("run faster than forced", 16'h0001, 16'(tl[2] < 2 * (2_000_000 / 6250)));
    stall = 1;
    hs_wait();
    chk("gates after sync loss", 16'h0000, 16'(hs));
    hs_wait();
    chk("restart after sync loss", 16'h0001, 16'(|hs));
    $display("test lead done");
    close_out();
  end
endmodule
